/* sldh_unit.sv */
/*
 * Execution unit for the short-format signed halfword load and the
 * general-format load, including interrupt abort and restart of the short load.
 * Assumes a bus that accepts withdrawal of an unanswered read request,
 * and an interrupt request line from logic on the same clock.
 */
// Summary of operation
// - Short-load address is element pointer plus zero-extended offset
// - Sign-extend halfword, write destination register
// - Decode opcode 1000 with seven displacement bits
// - Interrupt during short load abandons the instruction
// - Return address is the short load's address; after a general load, its next pc
// - Cycle type changes only with resource
// - Read may repeat after abort past read
// - General load never repeats its bus cycle
`timescale 1ns/1ps
module sldh_unit (
    input wire logic clock,
    input wire logic rst,
    // Short-format issue
    input wire logic short_valid,
    input wire logic [15:0] short_instr,
    input wire logic [31:0] short_pc,
    // General-format load issue
    input wire logic general_load_valid,
    input wire logic [31:0] general_load_addr,
    input wire logic [4:0] general_load_dest,
    input wire logic [31:0] general_load_next_pc,
    output logic issue_ready,
    // Element pointer operand
    input wire logic [31:0] element_pointer,
    // Memory bus read
    output logic bus_req,
    output logic [31:0] bus_addr,
    output logic [1:0] bus_size,
    output logic [1:0] bus_cycle_type,
    input wire logic bus_ack,
    input wire logic [15:0] bus_rdata,
    // General register file write port
    output logic general_register_file_we,
    output logic [4:0] destination_register,
    output logic [31:0] general_register_file_wdata,
    // Interrupt hand-off
    input wire logic irq_req,
    output logic irq_take,
    output logic [31:0] irq_return_pc
);
    // ==========================================================
    // Sequencer states
    typedef enum logic [2:0] {
        SLDH_IDLE,
        SLDH_SREAD,
        SLDH_SWB,
        SLDH_GREAD,
        SLDH_GWB
    } sldh_state_t;

    sldh_state_t state_q; // Current state
    sldh_state_t state_d; // Next state
    logic [31:0] addr_q; // Latched effective address
    logic [4:0] dest_q; // Latched destination index
    logic [31:0] pc_q; // Restart or resume address
    logic [15:0] half_q; // Captured read data
    logic [1:0] cyc_q; // Current bus cycle type
    logic irq_take_q; // Interrupt hand-off pulse
    logic [31:0] ret_q; // Saved return address
    logic we_q; // Register write pulse
    logic [31:0] wdata_q; // Register write data
    logic [4:0] wdest_q; // Register write index

    sldh_agen_if agen ();

    // Address and data path
    sldh_agen u_agen (
        .agen(agen.dp)
    );

    // ==========================================================
    // Instruction decode
    wire [3:0] opc_field;
    wire [6:0] disp_hi;
    wire [4:0] dest_field;
    wire [7:0] short_displacement;
    wire short_hit;
    assign opc_field = short_instr[sldh_pkg::OPC_LSB +: sldh_pkg::OPC_W];
    assign disp_hi = short_instr[0 +: sldh_pkg::DISP_HI_W];
    assign dest_field = short_instr[sldh_pkg::DEST_LSB +: sldh_pkg::REG_IDX_W];
    assign short_hit = short_valid && (opc_field == sldh_pkg::OPC_SHORT_LOAD_H);
    assign short_displacement = {disp_hi, sldh_pkg::ZERO_DISP_LSB};

    // Operands to the datapath
    assign agen.base = element_pointer;
    assign agen.offset = {24'h00_0000, short_displacement};
    assign agen.half = half_q;

    // ==========================================================
    // Handshake and event decode
    wire idle;
    wire short_start;
    wire general_start;
    wire short_abort;
    wire general_done;
    wire short_done;
    wire new_res;
    assign idle = state_q == SLDH_IDLE;
    assign issue_ready = idle;
    assign short_start = idle && short_hit; // Short load takes priority
    assign general_start = idle && !short_hit && general_load_valid;
    assign short_abort = irq_req && ((state_q == SLDH_SREAD) || (state_q == SLDH_SWB));
    assign short_done = (state_q == SLDH_SWB) && !irq_req;
    assign general_done = state_q == SLDH_GWB;
    assign new_res = short_start || general_start;

    // Bus outputs
    assign bus_req = (state_q == SLDH_SREAD && !irq_req) || (state_q == SLDH_GREAD);
    assign bus_addr = addr_q;
    assign bus_size = sldh_pkg::SLDH_SZ_HALF;
    assign bus_cycle_type = cyc_q;

    // Register write and interrupt outputs
    assign general_register_file_we = we_q;
    assign destination_register = wdest_q;
    assign general_register_file_wdata = wdata_q;
    assign irq_take = irq_take_q;
    assign irq_return_pc = ret_q;

    // ==========================================================
    // Next state
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            SLDH_IDLE:
            begin
                // Start whichever load is issued
                if (short_start)
                    state_d = SLDH_SREAD;
                else if (general_start)
                    state_d = SLDH_GREAD;
            end
            SLDH_SREAD:
            begin
                // Abandon on interrupt, even mid-read
                if (irq_req)
                    state_d = SLDH_IDLE;
                else if (bus_ack)
                    state_d = SLDH_SWB;
            end
            SLDH_SWB:
            begin
                // Read already done, still abandoned on interrupt
                state_d = SLDH_IDLE;
            end
            SLDH_GREAD:
            begin
                // Not abortable; read runs to its end
                if (bus_ack)
                    state_d = SLDH_GWB;
            end
            SLDH_GWB:
                state_d = SLDH_IDLE;
            default:
                state_d = SLDH_IDLE;
        endcase
    end

    // ==========================================================
    // State register
    always_ff @(posedge clock)
    begin
        if (rst)
            state_q <= SLDH_IDLE;
        else
            state_q <= state_d;
    end

    // ==========================================================
    // Operand capture at issue
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            addr_q <= sldh_pkg::DATA_RESET;
            dest_q <= 5'h00;
            pc_q <= sldh_pkg::PC_RESET;
        end
        else if (short_start)
        begin
            addr_q <= agen.addr;
            dest_q <= dest_field;
            pc_q <= short_pc;
        end
        else if (general_start)
        begin
            addr_q <= general_load_addr;
            dest_q <= general_load_dest;
            pc_q <= general_load_next_pc;
        end
    end

    // ==========================================================
    // Bus cycle type, held while the resource is unchanged
    always_ff @(posedge clock)
    begin
        if (rst)
            cyc_q <= sldh_pkg::SLDH_RES_ROM;
        else if (new_res && (cyc_q != agen.res) && short_start)
            cyc_q <= agen.res;
        else if (new_res && general_start)
            cyc_q <= sldh_res_of(general_load_addr);
    end

    // Resource class of a general-load address
    function automatic logic [1:0] sldh_res_of(input logic [31:0] a);
        logic [1:0] r;
        r = sldh_pkg::SLDH_RES_ROM;
        if (a >= sldh_pkg::EXT_BASE)
            r = sldh_pkg::SLDH_RES_EXT;
        else if (a >= sldh_pkg::IO_BASE)
            r = sldh_pkg::SLDH_RES_IO;
        else if (a >= sldh_pkg::RAM_BASE)
            r = sldh_pkg::SLDH_RES_RAM;
        return r;
    endfunction : sldh_res_of

    // ==========================================================
    // Read data capture
    always_ff @(posedge clock)
    begin
        if (rst)
            half_q <= 16'h0000;
        else if (bus_req && bus_ack)
            half_q <= bus_rdata;
    end

    // ==========================================================
    // Register file write, skipped when the load is abandoned
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            we_q <= 1'b0;
            wdest_q <= 5'h00;
            wdata_q <= sldh_pkg::DATA_RESET;
        end
        else
        begin
            we_q <= short_done || general_done;
            wdest_q <= dest_q;
            wdata_q <= agen.wide;
        end
    end

    // ==========================================================
    // Interrupt hand-off with return address
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            irq_take_q <= 1'b0;
            ret_q <= sldh_pkg::PC_RESET;
        end
        else if (short_abort)
        begin
            irq_take_q <= 1'b1;
            ret_q <= pc_q;
        end
        else if (general_done && irq_req)
        begin
            irq_take_q <= 1'b1;
            ret_q <= pc_q;
        end
        else
            irq_take_q <= 1'b0;
    end
endmodule : sldh_unit

/* sldh_pkg.sv */
/*
 * Constants and types for the short-format signed halfword load unit.
 * Assumes a 32-bit core with a 32-entry general register file.
 */
package sldh_pkg;
    // ==========================================================
    // Widths
    localparam int unsigned XLEN = 32;
    localparam int unsigned REG_IDX_W = 5;
    localparam int unsigned HALF_W = 16;
    localparam int unsigned INSTR_W = 16;

    // ==========================================================
    // Encoding fields
    localparam int unsigned DEST_LSB = 11; // Destination register field
    localparam int unsigned OPC_LSB = 7; // Opcode field
    localparam int unsigned OPC_W = 4;
    localparam logic [3:0] OPC_SHORT_LOAD_H = 4'h8; // Pattern 1000
    localparam int unsigned DISP_HI_W = 7; // Upper displacement bits
    localparam int unsigned SHORT_DISP_W = 8;
    localparam logic ZERO_DISP_LSB = 1'b0; // Forced even offset

    // ==========================================================
    // Resource map (base of each window)
    localparam logic [31:0] RAM_BASE = 32'h0300_0000;
    localparam logic [31:0] IO_BASE = 32'h0400_0000;
    localparam logic [31:0] EXT_BASE = 32'h0500_0000;

    // ==========================================================
    // Reset values
    localparam logic [31:0] PC_RESET = 32'h0000_0000;
    localparam logic [31:0] DATA_RESET = 32'h0000_0000;

    // Target resource class, selects the bus cycle type
    typedef enum logic [1:0] {
        SLDH_RES_ROM,
        SLDH_RES_RAM,
        SLDH_RES_IO,
        SLDH_RES_EXT
    } sldh_res_t;

    // Size field of a bus read
    typedef enum logic [1:0] {
        SLDH_SZ_BYTE,
        SLDH_SZ_HALF,
        SLDH_SZ_WORD
    } sldh_size_t;
endpackage : sldh_pkg

/* sldh_agen_if.sv */
/*
 * Carrier between the load sequencer and its address and data path.
 * Assumes both ends sit on the same core clock.
 */
`timescale 1ns/1ps
interface sldh_agen_if;
    logic [31:0] base; // Base address operand
    logic [31:0] offset; // Zero-extended offset
    logic [31:0] addr; // Effective address
    sldh_pkg::sldh_res_t res; // Resource behind the address
    logic [15:0] half; // Raw halfword from the bus
    logic [31:0] wide; // Sign-extended halfword

    // ==========================================================
    // Sequencer side
    modport seq (
        output base,
        output offset,
        output half,
        input addr,
        input res,
        input wide
    );

    // ==========================================================
    // Datapath side
    modport dp (
        input base,
        input offset,
        input half,
        output addr,
        output res,
        output wide
    );
endinterface : sldh_agen_if

/* sldh_agen.sv */
/*
 * Address adder, resource decoder and sign extender.
 * Assumes the sequencer holds its operands stable while it uses results.
 */
`timescale 1ns/1ps
module sldh_agen (
    sldh_agen_if.dp agen
);
    // ==========================================================
    // Address forming
    wire [32:0] addr_sum;
    assign addr_sum = {1'b0, agen.base} + {1'b0, agen.offset};
    assign agen.addr = addr_sum[31:0];

    // ==========================================================
    // Resource decode by address window
    wire hit_ext;
    wire hit_io;
    wire hit_ram;
    assign hit_ext = agen.addr >= sldh_pkg::EXT_BASE;
    assign hit_io = agen.addr >= sldh_pkg::IO_BASE;
    assign hit_ram = agen.addr >= sldh_pkg::RAM_BASE;
    assign agen.res = hit_ext ? sldh_pkg::SLDH_RES_EXT :
                      hit_io ? sldh_pkg::SLDH_RES_IO :
                      hit_ram ? sldh_pkg::SLDH_RES_RAM : sldh_pkg::SLDH_RES_ROM;

    // ==========================================================
    // Sign extension of the loaded halfword
    assign agen.wide = {{(sldh_pkg::XLEN - sldh_pkg::HALF_W){agen.half[15]}}, agen.half};
endmodule : sldh_agen

/* sldh_unit_assertions.sv */
/* Checker for the halfword load unit.
   Assumes it is bound onto sldh_unit, one clock domain. */
`timescale 1ns/1ps
module sldh_unit_assertions (
    input wire logic clock,
    input wire logic rst,
    input wire logic short_valid,
    input wire logic [15:0] short_instr,
    input wire logic [31:0] short_pc,
    input wire logic general_load_valid,
    input wire logic [31:0] general_load_addr,
    input wire logic [4:0] general_load_dest,
    input wire logic [31:0] general_load_next_pc,
    input wire logic issue_ready,
    input wire logic [31:0] element_pointer,
    input wire logic bus_req,
    input wire logic [31:0] bus_addr,
    input wire logic [1:0] bus_size,
    input wire logic [1:0] bus_cycle_type,
    input wire logic bus_ack,
    input wire logic [15:0] bus_rdata,
    input wire logic general_register_file_we,
    input wire logic [4:0] destination_register,
    input wire logic [31:0] general_register_file_wdata,
    input wire logic irq_req,
    input wire logic irq_take,
    input wire logic [31:0] irq_return_pc
);
    // ==========================================================
    // Shadow of the instruction in flight
    wire short_hit = short_valid && short_instr[10:7] == sldh_pkg::OPC_SHORT_LOAD_H;
    wire issue = issue_ready && (short_hit || general_load_valid);
    // Resource class from the address windows, open-ended at the top
    wire [1:0] res_exp = bus_addr >= sldh_pkg::EXT_BASE ? 2'h3 : bus_addr >= sldh_pkg::IO_BASE ? 2'h2 :
        bus_addr >= sldh_pkg::RAM_BASE ? 2'h1 : 2'h0;
    logic short_q; // Instruction in flight is the short load
    logic [31:0] ea_q; // Expected read address
    logic [31:0] pc_q; // Address of the short load
    logic [4:0] dest_q; // Expected destination
    logic [15:0] rd_q; // Halfword taken from the bus
    // Capture at issue and at read completion
    always_ff @(posedge clock)
    begin
        if (rst)
            short_q <= 1'b0;
        else if (issue)
            short_q <= short_hit;
        if (issue)
        begin
            ea_q <= short_hit ? element_pointer + {24'h0, short_instr[6:0], 1'b0} : general_load_addr;
            pc_q <= short_pc;
            dest_q <= short_hit ? short_instr[15:11] : general_load_dest;
        end
        if (bus_req && bus_ack)
            rd_q <= bus_rdata;
    end
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    sequence s_ack;
        bus_req && bus_ack;
    endsequence
    sequence s_wb_ok;
        s_ack ##1 (!irq_req || !short_q);
    endsequence
    sequence s_abort;
        short_q && !issue_ready && irq_req && !general_register_file_we && !irq_take;
    endsequence
    // ==========================================================
    // Properties
    size_half_a: assert property (bus_req |-> bus_size == 2'h1) else $error("read size wrong");
    addr_eff_a: assert property (bus_req |-> bus_addr == ea_q) else $error("read address wrong");
    type_match_a: assert property (bus_req |-> bus_cycle_type == res_exp) else $error("cycle type wrong");
    req_hold_a: assert property (bus_req && !bus_ack |=> (bus_req || irq_req) && $stable(bus_addr))
        else $error("request not held");
    write_data_a: assert property (s_wb_ok |=> general_register_file_we && destination_register == dest_q
        && general_register_file_wdata == {{16{rd_q[15]}}, rd_q}) else $error("write wrong");
    we_pulse_a: assert property (general_register_file_we |=> !general_register_file_we) else $error("long we");
    abort_take_a: assert property (s_abort |=> irq_take && irq_return_pc == pc_q && !general_register_file_we)
        else $error("abort wrong");
    irq_drop_a: assert property (short_q && irq_req && !issue_ready |-> !bus_req) else $error("read kept");
    take_pulse_a: assert property (irq_take |=> !irq_take) else $error("long take");
    gen_once_a: assert property (bus_req && bus_ack && !short_q |=> !bus_req ##1 (!bus_req && issue_ready))
        else $error("read repeated");
endmodule : sldh_unit_assertions

bind sldh_unit sldh_unit_assertions sldh_unit_assertions_i (.clock, .rst, .short_valid, .short_instr, .short_pc,
    .general_load_valid, .general_load_addr, .general_load_dest, .general_load_next_pc, .issue_ready,
    .element_pointer, .bus_req, .bus_addr, .bus_size, .bus_cycle_type, .bus_ack, .bus_rdata,
    .general_register_file_we, .destination_register, .general_register_file_wdata, .irq_req, .irq_take,
    .irq_return_pc);

/* sldh_bus_model.sv */
/* Memory bus responder for the load unit.
   Assumes one clock; data is a fold of the address. */
`timescale 1ns/1ps
module sldh_bus_model (
    input wire logic clock,
    input wire logic rst,
    input wire logic bus_req,
    input wire logic [31:0] bus_addr,
    input wire logic [3:0] lat,
    output logic bus_ack,
    output logic [15:0] bus_rdata,
    output logic [7:0] reads
);
    logic [3:0] wait_q; // Cycles waited so far
    wire hit = bus_req && !bus_ack && wait_q == lat;
    // Ack comes lat+1 cycles after the request rises; released data toggles
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            wait_q <= 4'h0;
            bus_ack <= 1'b0;
            bus_rdata <= 16'h0000;
            reads <= 8'h00;
        end
        else
        begin
            bus_ack <= hit;
            wait_q <= (bus_req && !bus_ack && !hit) ? wait_q + 4'h1 : 4'h0;
            bus_rdata <= hit ? bus_addr[31:16] ^ bus_addr[15:0] : ~bus_rdata;
            if (bus_req && bus_ack)
                reads <= reads + 8'h01;
        end
    end
endmodule : sldh_bus_model

/* tb.sv */
/* Self-checking bench for the halfword load unit.
   Assumes the bus model and the bound checker. */
`timescale 1ns/1ps
module tb;
    logic clock, rst, short_valid, general_load_valid, issue_ready, bus_req, bus_ack;
    logic general_register_file_we, irq_req, irq_take;
    logic [15:0] short_instr, bus_rdata;
    logic [31:0] short_pc, general_load_addr, general_load_next_pc, element_pointer, bus_addr;
    logic [31:0] general_register_file_wdata, irq_return_pc;
    logic [4:0] general_load_dest, destination_register;
    logic [1:0] bus_size, bus_cycle_type;
    logic [3:0] lat;
    logic [7:0] reads, r0;
    int bad_count, comparisons;
    always #4 clock = ~clock;
    sldh_unit sldh_unit_i (.clock, .rst, .short_valid, .short_instr, .short_pc, .general_load_valid,
        .general_load_addr, .general_load_dest, .general_load_next_pc, .issue_ready, .element_pointer,
        .bus_req, .bus_addr, .bus_size, .bus_cycle_type, .bus_ack, .bus_rdata, .general_register_file_we,
        .destination_register, .general_register_file_wdata, .irq_req, .irq_take, .irq_return_pc);
    sldh_bus_model sldh_bus_model_i (.clock, .rst, .bus_req, .bus_addr, .lat, .bus_ack, .bus_rdata, .reads);
    // ==========================================================
    // Helpers
    task automatic report_and_stop;
        $display("comparisons %0d bad_count %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : report_and_stop
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_word
    task automatic chk_bit(input logic got, input logic exp);
        chk_word({31'h0, got}, {31'h0, exp});
    endtask : chk_bit
    task automatic tick;
        @(posedge clock);
        #1;
    endtask : tick
    // Signal picked for a bounded wait: 0 ack, 1 register write, else take
    function automatic logic sig_of(input int sel);
        case (sel)
            0: return bus_ack;
            1: return general_register_file_we;
            default: return irq_take;
        endcase
    endfunction : sig_of
    task automatic wait_hi(input int sel);
        int n;
        n = 0;
        while (sig_of(sel) !== 1'b1 && n < 40)
        begin
            tick();
            n++;
        end
        if (sig_of(sel) !== 1'b1)
        begin
            bad_count++;
            report_and_stop();
        end
    endtask : wait_hi
    function automatic logic [31:0] exp_word(input logic [31:0] a);
        logic [15:0] h;
        h = a[31:16] ^ a[15:0];
        return {{16{h[15]}}, h};
    endfunction : exp_word
    task automatic issue(input logic s, input logic [15:0] ins, input logic [31:0] ep);
        short_valid = s;
        general_load_valid = !s;
        short_instr = ins;
        element_pointer = ep;
        tick();
        short_valid = 1'b0;
        general_load_valid = 1'b0;
    endtask : issue
    task automatic check_write(input logic [31:0] d, input logic [4:0] r);
        wait_hi(1);
        chk_word(general_register_file_wdata, d);
        chk_word({27'h0, destination_register}, {27'h0, r});
    endtask : check_write
    // ==========================================================
    // Scenarios
    task automatic sc_decode;
        logic [31:0] eps [4] = '{32'h0000_1000, 32'h0300_9000, 32'h0400_3ffe, 32'h0500_f000};
        logic [6:0] ds [4] = '{7'h00, 7'h7f, 7'h40, 7'h01};
        for (int i = 0; i < 4; i++)
        begin
            lat = i[3:0];
            issue(1'b1, {5'h3 + i[4:0], 4'h8, ds[i]}, eps[i]);
            chk_word({30'h0, bus_cycle_type}, {30'h0, i[1:0]});
            check_write(exp_word(eps[i] + {24'h0, ds[i], 1'b0}), 5'h3 + i[4:0]);
        end
        short_valid = 1'b1;
        short_instr = {5'h1, 4'h9, 7'h00};
        tick();
        tick();
        short_valid = 1'b0;
        chk_bit(bus_req, 1'b0);
        chk_bit(issue_ready, 1'b1);
    endtask : sc_decode
    task automatic sc_abort_wb;
        lat = 4'h0;
        short_pc = 32'h0000_0200;
        r0 = reads;
        issue(1'b1, {5'h7, 4'h8, 7'h10}, 32'h0300_0000);
        wait_hi(0);
        tick();
        irq_req = 1'b1;
        tick();
        irq_req = 1'b0;
        chk_bit(irq_take, 1'b1);
        chk_word(irq_return_pc, 32'h0000_0200);
        chk_bit(general_register_file_we, 1'b0);
        issue(1'b1, {5'h7, 4'h8, 7'h10}, 32'h0300_0000);
        check_write(exp_word(32'h0300_0020), 5'h7);
        chk_word({24'h0, reads}, {24'h0, r0 + 8'h02});
    endtask : sc_abort_wb
    task automatic sc_abort_read;
        lat = 4'h6;
        short_pc = 32'h0000_0300;
        r0 = reads;
        issue(1'b1, {5'h9, 4'h8, 7'h02}, 32'h0400_0000);
        tick();
        irq_req = 1'b1;
        tick();
        irq_req = 1'b0;
        chk_bit(irq_take, 1'b1);
        chk_word(irq_return_pc, 32'h0000_0300);
        repeat (8) tick();
        chk_word({24'h0, reads}, {24'h0, r0});
    endtask : sc_abort_read
    task automatic sc_general;
        lat = 4'h2;
        general_load_addr = 32'h0400_1234;
        general_load_dest = 5'h1f;
        general_load_next_pc = 32'h0000_0404;
        r0 = reads;
        issue(1'b0, 16'h0000, 32'h0);
        irq_req = 1'b1;
        check_write(exp_word(32'h0400_1234), 5'h1f);
        wait_hi(2);
        irq_req = 1'b0;
        chk_word(irq_return_pc, 32'h0000_0404);
        chk_word({24'h0, reads}, {24'h0, r0 + 8'h01});
    endtask : sc_general
    // Mid-run reset drops the load in flight and clears every output except issue_ready and bus_size
    task automatic sc_reset;
        lat = 4'h5;
        issue(1'b1, {5'h2, 4'h8, 7'h00}, 32'h0500_0000);
        chk_bit(bus_req, 1'b1);
        chk_word({30'h0, bus_cycle_type}, 32'h0000_0003);
        rst = 1'b1;
        tick();
        tick();
        rst = 1'b0;
        chk_bit(bus_req, 1'b0);
        chk_bit(issue_ready, 1'b1);
        chk_bit(general_register_file_we, 1'b0);
        chk_bit(irq_take, 1'b0);
        chk_word(irq_return_pc, sldh_pkg::PC_RESET);
        chk_word({30'h0, bus_cycle_type}, 32'h0000_0000);
    endtask : sc_reset
    // ==========================================================
    // Main sequence
    initial
    begin
        {clock, rst, short_valid, general_load_valid, irq_req} = 5'h08;
        {short_instr, short_pc, element_pointer, lat} = '0;
        {general_load_addr, general_load_dest, general_load_next_pc} = '0;
        bad_count = 0;
        comparisons = 0;
        repeat (20) tick();
        chk_bit(bus_req, 1'b0);
        rst = 1'b0;
        sc_decode();
        sc_abort_wb();
        sc_abort_read();
        sc_reset();
        sc_general();
        report_and_stop();
    end
endmodule : tb
